//--- core/trace_framer_pkg.sv
/*
 Constants, register map and state types of the trace source packet framer.
 Assumes an APB master with 12-bit byte addresses and 32-bit data.
*/
package trace_framer_pkg;

	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_PAGE   = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	// Stimulus ports occupy 0x400..0x7fc, one word per port
	localparam logic [1:0]  STIM_WIN   = 2'h1;

	localparam int CTRL_EN_BIT     = 0;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_BAD_BIT  = 1;
	localparam int STATUS_HOLD_BIT = 2;
	localparam int STATUS_LVL_LSB  = 8;

	localparam logic       CTRL_EN_RST = 1'b0;
	localparam logic [2:0] PAGE_RST    = 3'h0;

	localparam logic [1:0] SZ_NONE = 2'h0;
	localparam logic [1:0] SZ_BYTE = 2'h1;
	localparam logic [1:0] SZ_HALF = 2'h2;
	localparam logic [1:0] SZ_WORD = 2'h3;

	localparam logic EXT_MARK   = 1'b1;
	localparam logic SRC_INSTR  = 1'b0;
	localparam logic SRC_HW     = 1'b1;
	localparam logic ORIGIN_INS = 1'b0;
	localparam logic CONT_LAST  = 1'b0;

	// FIFO entry: header byte above a 32-bit payload
	localparam int ENTRY_W = 40;

	typedef enum logic [1:0] {
		SER_IDLE    = 2'h0,
		SER_PAYLOAD = 2'h1
	} ser_state_t;

endpackage

//--- core/trace_source_packet_framer.sv
/*
 Trace source packet framer: APB register slave with stimulus ports, a
 holding slot for watch unit packets, an entry FIFO and a byte serializer.
 Assumes all inputs come from logic on clk_sys and that the output arbiter
 takes bytes with a valid/ready handshake.
*/
`timescale 1ns/1ns

module trace_entry_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [CW-1:0]    level
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [CW-1:0]    next_level;
	logic             push;
	logic             pop;

	assign in_ready  = (level != CW'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr];

	always_comb begin
		push        = in_valid & in_ready;
		pop         = out_valid & out_ready;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_level  = level;
		if (push) begin
			next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
		end
		if (push & ~pop) begin
			next_level = level + 1'b1;
		end else if (pop & ~push) begin
			next_level = level - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else if (ce) begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			level  <= next_level;
			if (push) begin
				mem[wr_ptr] <= in_data;
			end
		end
	end

endmodule // trace_entry_fifo

module trace_source_packet_framer
	import trace_framer_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hw_valid,
	output logic             hw_ready,
	input  wire logic [4:0]  hw_id,
	input  wire logic [1:0]  hw_size,
	input  wire logic [31:0] hw_data,
	input  wire logic        sync_done,
	output logic             trace_valid,
	output logic      [7:0]  trace_byte,
	output logic             trace_last,
	input  wire logic        trace_ready
);
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	logic               trace_en;
	logic [2:0]         page;
	logic               hw_bad;
	logic               hold_full;
	logic [ENTRY_W-1:0] hold_entry;
	logic               next_trace_en;
	logic [2:0]         next_page;
	logic               next_hw_bad;
	logic               next_hold_full;
	logic [ENTRY_W-1:0] next_hold_entry;
	logic               next_hw_ready;
	logic [31:0]        next_prdata;
	logic               next_pready;
	logic               next_pslverr;

	logic               fifo_in_valid;
	logic               fifo_in_ready;
	logic [ENTRY_W-1:0] fifo_in_data;
	logic               fifo_out_valid;
	logic               fifo_pop;
	logic [ENTRY_W-1:0] fifo_out_data;
	logic [CW-1:0]      fifo_level;

	logic               access;
	logic               stim_sel;
	logic [2:0]         port_page;
	logic [4:0]         port_id;
	logic               strb_ok;
	logic [1:0]         strb_size;
	logic [31:0]        strb_data;
	logic               sw_push;
	logic [ENTRY_W-1:0] sw_entry;
	logic               sw_slot;

	ser_state_t         ser_state;
	ser_state_t         next_ser_state;
	logic [31:0]        shift;
	logic [31:0]        next_shift;
	logic [2:0]         left;
	logic [2:0]         next_left;
	logic               next_trace_valid;
	logic [7:0]         next_trace_byte;
	logic               next_trace_last;
	logic               busy;

	function automatic logic [2:0] payload_bytes(input logic [1:0] ss);
		case (ss)
			SZ_BYTE: payload_bytes = 3'h1;
			SZ_HALF: payload_bytes = 3'h2;
			SZ_WORD: payload_bytes = 3'h4;
			default: payload_bytes = 3'h0;
		endcase
	endfunction

	assign access    = psel & penable & ~pready;
	assign stim_sel  = (paddr[11:10] == STIM_WIN);
	assign port_page = paddr[9:7];
	assign port_id   = paddr[6:2];
	// The watch unit slot wins the FIFO; its slot empties for at least
	// one cycle per packet, in which a stimulus write can go in unless the FIFO is full.
	assign sw_slot   = fifo_in_ready & ~hold_full;
	assign busy      = (ser_state != SER_IDLE) | trace_valid |
	                   fifo_out_valid | hold_full;

	always_comb begin
		strb_ok   = 1'b1;
		strb_size = SZ_NONE;
		strb_data = 32'h0;
		case (pstrb)
			4'h1: begin
				strb_size = SZ_BYTE;
				strb_data = {24'h0, pwdata[7:0]};
			end
			4'h2: begin
				strb_size = SZ_BYTE;
				strb_data = {24'h0, pwdata[15:8]};
			end
			4'h4: begin
				strb_size = SZ_BYTE;
				strb_data = {24'h0, pwdata[23:16]};
			end
			4'h8: begin
				strb_size = SZ_BYTE;
				strb_data = {24'h0, pwdata[31:24]};
			end
			4'h3: begin
				strb_size = SZ_HALF;
				strb_data = {16'h0, pwdata[15:0]};
			end
			4'hc: begin
				strb_size = SZ_HALF;
				strb_data = {16'h0, pwdata[31:16]};
			end
			4'hf: begin
				strb_size = SZ_WORD;
				strb_data = pwdata;
			end
			default: begin
				// Empty, scattered, misaligned or three-lane strobes match no access size
				strb_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_trace_en   = trace_en;
		next_page       = page;
		next_hw_bad     = hw_bad;
		next_hold_full  = hold_full;
		next_hold_entry = hold_entry;
		next_prdata     = 32'h0;
		next_pready     = 1'b0;
		next_pslverr    = 1'b0;
		sw_push         = 1'b0;
		sw_entry        = '0;
		if (access) begin
			if (stim_sel && pwrite) begin
				if (!trace_en) begin
					next_pready = 1'b1;
				end else if (!strb_ok) begin
					next_pready  = 1'b1;
					next_pslverr = 1'b1;
				end else if (sw_slot && port_page != page) begin
					// Announce the page first; the write itself waits
					sw_push  = 1'b1;
					sw_entry = {CONT_LAST, port_page, EXT_MARK,
					            ORIGIN_INS, SZ_NONE, 32'h0};
					next_page = port_page;
				end else if (sw_slot) begin
					sw_push  = 1'b1;
					sw_entry = {port_id, SRC_INSTR, strb_size,
					            strb_data};
					next_pready = 1'b1;
				end
			end else if (stim_sel) begin
				next_prdata = {31'h0, sw_slot};
				next_pready = 1'b1;
			end else begin
				next_pready = 1'b1;
				case (paddr)
					OFS_CTRL: begin
						if (pwrite) begin
							if (pstrb[0]) begin
								next_trace_en = pwdata[CTRL_EN_BIT];
							end
						end else begin
							next_prdata[CTRL_EN_BIT] = trace_en;
						end
					end
					OFS_PAGE: begin
						next_prdata[2:0] = page;
						next_pslverr = pwrite;
					end
					OFS_STATUS: begin
						if (pwrite && pstrb[0] && pwdata[STATUS_BAD_BIT]) begin
							next_hw_bad = 1'b0;
						end
						next_prdata[STATUS_BUSY_BIT] = busy;
						next_prdata[STATUS_BAD_BIT]  = hw_bad;
						next_prdata[STATUS_HOLD_BIT] = hold_full;
						next_prdata[STATUS_LVL_LSB +: 8] = 8'(fifo_level);
					end
					default: begin
						next_pslverr = 1'b1;
					end
				endcase
			end
		end
		if (sync_done) begin
			next_page = PAGE_RST;
		end
		if (hold_full && fifo_in_ready) begin
			next_hold_full = 1'b0;
		end
		if (hw_valid && hw_ready) begin
			if (hw_size == SZ_NONE) begin
				// Reserved size is dropped and flagged; set beats clear
				next_hw_bad = 1'b1;
			end else begin
				next_hold_full  = 1'b1;
				next_hold_entry = {hw_id, SRC_HW, hw_size,
				                   hw_data};
			end
		end
		next_hw_ready = ~next_hold_full;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			trace_en   <= CTRL_EN_RST;
			page       <= PAGE_RST;
			hw_bad     <= 1'b0;
			hold_full  <= 1'b0;
			hold_entry <= '0;
			hw_ready   <= 1'b0;
			prdata     <= 32'h0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
		end else if (ce) begin
			trace_en   <= next_trace_en;
			page       <= next_page;
			hw_bad     <= next_hw_bad;
			hold_full  <= next_hold_full;
			hold_entry <= next_hold_entry;
			hw_ready   <= next_hw_ready;
			prdata     <= next_prdata;
			pready     <= next_pready;
			pslverr    <= next_pslverr;
		end
	end

	assign fifo_in_valid = hold_full | sw_push;
	assign fifo_in_data  = hold_full ? hold_entry : sw_entry;

	trace_entry_fifo #(
		.WIDTH (ENTRY_W),
		.DEPTH (FIFO_DEPTH),
		.CW    (CW)
	) u_fifo (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.ce        (ce),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	always_comb begin
		next_ser_state   = ser_state;
		next_shift       = shift;
		next_left        = left;
		next_trace_valid = trace_valid;
		next_trace_byte  = trace_byte;
		next_trace_last  = trace_last;
		fifo_pop         = 1'b0;
		if (!trace_valid || trace_ready) begin
			next_trace_valid = 1'b0;
			next_trace_last  = 1'b0;
			case (ser_state)
				SER_IDLE: begin
					if (fifo_out_valid) begin
						fifo_pop         = 1'b1;
						next_trace_valid = 1'b1;
						next_trace_byte  = fifo_out_data[39:32];
						next_shift       = fifo_out_data[31:0];
						next_left        = payload_bytes(fifo_out_data[33:32]);
						next_trace_last  = (next_left == 3'h0);
						if (next_left != 3'h0) begin
							next_ser_state = SER_PAYLOAD;
						end
					end
				end
				SER_PAYLOAD: begin
					next_trace_valid = 1'b1;
					next_trace_byte  = shift[7:0];
					next_shift       = {8'h0, shift[31:8]};
					next_left        = left - 3'h1;
					next_trace_last  = (left == 3'h1);
					if (left == 3'h1) begin
						next_ser_state = SER_IDLE;
					end
				end
				default: begin
					next_ser_state = SER_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ser_state   <= SER_IDLE;
			shift       <= 32'h0;
			left        <= 3'h0;
			trace_valid <= 1'b0;
			trace_byte  <= 8'h0;
			trace_last  <= 1'b0;
		end else if (ce) begin
			ser_state   <= next_ser_state;
			shift       <= next_shift;
			left        <= next_left;
			trace_valid <= next_trace_valid;
			trace_byte  <= next_trace_byte;
			trace_last  <= next_trace_last;
		end
	end

endmodule // trace_source_packet_framer

//--- tb/trace_framer_monitor.sv
/*
 Port checker for the trace source packet framer.
 Bound to every framer instance; sees only the top module's ports.
*/
`timescale 1ns/1ns
module trace_framer_monitor (
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic        ce,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        hw_valid,
	input wire logic        hw_ready,
	input wire logic [1:0]  hw_size,
	input wire logic        trace_valid,
	input wire logic [7:0]  trace_byte,
	input wire logic        trace_last,
	input wire logic        trace_ready
);
	logic       first;
	logic [2:0] rem;
	wire logic  take = trace_valid && trace_ready && ce;

	// Tracks packet start and the bytes still owed after each header
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			first <= 1'b1;
			rem   <= 3'h0;
		end else if (take) begin
			first <= trace_last;
			if (first)
				rem <= (trace_byte[1:0] == 2'h3) ? 3'h4 : {1'b0, trace_byte[1:0]};
			else
				rem <= rem - 3'h1;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	hold_byte_a: assert property (trace_valid && !trace_ready |=>
		trace_valid && $stable(trace_byte) && $stable(trace_last))
		else $error("trace byte changed before taken");
	ext_header_a: assert property (
		trace_valid && first && trace_byte[1:0] == 2'h0 |->
		trace_byte[7] == 1'b0 && trace_byte[3:2] == 2'h2 && trace_last)
		else $error("bad extension header");
	src_header_a: assert property (
		trace_valid && first && trace_byte[1:0] != 2'h0 |-> !trace_last)
		else $error("source header without payload");
	last_pos_a: assert property (
		trace_valid && !first |-> trace_last == (rem == 3'h1))
		else $error("payload length wrong");
	pready_pulse_a: assert property (pready && ce |=> !pready)
		else $error("pready longer than one cycle");
	err_qual_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside answer");
	// A reserved-size offer is dropped, so the slot stays open after it
	hw_take_a: assert property (
		hw_valid && hw_ready && ce && hw_size != 2'h0 |=> !hw_ready)
		else $error("hw_ready did not drop after take");
	reset_quiet_a: assert property (disable iff (1'b0)
		srst |=> !trace_valid && !pready && !hw_ready)
		else $error("outputs active after reset");

	cover property (take && first && trace_byte[1:0] == 2'h0);
	cover property (take && first && trace_byte[2]);
	cover property (pready && pslverr);
	cover property (hw_valid && !hw_ready);
endmodule // trace_framer_monitor

bind trace_source_packet_framer trace_framer_monitor trace_framer_monitor_inst (
	.clk_sys, .srst, .ce, .pready, .pslverr, .prdata, .hw_valid,
	.hw_ready, .hw_size, .trace_valid, .trace_byte, .trace_last,
	.trace_ready);

//--- tb/trace_arbiter_model.sv
/*
 Model of the trace output arbiter that takes framed bytes.
 Assumes one clock; mode 0 prompt, 1 slow, 2 stalled.
*/
`timescale 1ns/1ns
module trace_arbiter_model (
	input wire logic       clk_sys,
	input wire logic       srst,
	input wire logic [1:0] mode,
	input wire logic       trace_valid,
	input wire logic [7:0] trace_byte,
	input wire logic       trace_last,
	output logic           trace_ready
);
	logic [8:0] got[$];
	logic [1:0] ph;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ph          <= 2'h0;
			trace_ready <= 1'b0;
		end else begin
			// Byte counts only at an edge with valid and ready
			if (trace_valid && trace_ready)
				got.push_back({trace_last, trace_byte});
			ph          <= ph + 2'h1;
			trace_ready <= mode == 2'h0 || (mode == 2'h1 && ph == 2'h3);
		end
	end
endmodule // trace_arbiter_model

//--- tb/trace_source_packet_framer_tb.sv
/*
 Self-checking bench for the trace source packet framer.
 Drives APB and the watch unit side; the arbiter model takes bytes.
*/
`timescale 1ns/1ns
module trace_source_packet_framer_tb;
	import trace_framer_pkg::*;
	logic        clk_sys, srst, ce, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, hw_data, rd;
	logic [3:0]  pstrb;
	logic [4:0]  hw_id;
	logic [1:0]  hw_size, mode;
	logic        pready, pslverr, hw_valid, hw_ready, sync_done, er;
	logic        trace_valid, trace_last, trace_ready;
	logic [7:0]  trace_byte;
	int          err_total, n_compared;

	trace_source_packet_framer #(.FIFO_DEPTH(8)) trace_source_packet_framer_inst (
		.clk_sys, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .hw_valid, .hw_ready, .hw_id,
		.hw_size, .hw_data, .sync_done, .trace_valid, .trace_byte,
		.trace_last, .trace_ready);
	trace_arbiter_model trace_arbiter_model_inst (.clk_sys, .srst, .mode,
		.trace_valid, .trace_byte, .trace_last, .trace_ready);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic hw(input logic [4:0] id, input logic [1:0] s,
		input logic [31:0] d);
		@(posedge clk_sys);
		hw_valid <= 1'b1;
		hw_id    <= id;
		hw_size  <= s;
		hw_data  <= d;
		do begin
			@(posedge clk_sys);
		end while (hw_ready !== 1'b1);
		hw_valid <= 1'b0;
	endtask

	// Header then n payload bytes, least significant first, last flagged
	task automatic pkt(input logic [7:0] h, input logic [31:0] d, input int n);
		logic [8:0] b;
		int t;
		for (int i = 0; i <= n; i++) begin
			t = 0;
			while (trace_arbiter_model_inst.got.size() == 0 && t < 300) begin
				@(posedge clk_sys);
				t++;
			end
			b = trace_arbiter_model_inst.got.pop_front();
			chk(b, {i == n, (i == 0) ? h : d[7:0]});
			if (i > 0)
				d = d >> 8;
		end
	endtask

	task automatic t_regs();
		apb(1'b1, 12'h400, 32'h99, 4'h1); // Dropped while disabled
		apb(1'b0, OFS_CTRL, 32'h0, 4'h0);
		chk(rd, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h1, 4'hf);
		apb(1'b0, OFS_CTRL, 32'h0, 4'h0);
		chk(rd, 32'h1);
		apb(1'b1, OFS_PAGE, 32'h5, 4'hf);
		chk(er, 1'b1);
		apb(1'b0, OFS_PAGE, 32'h0, 4'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h100, 32'h0, 4'h0);
		chk(er, 1'b1);
		$display("TB: registers done");
	endtask

	task automatic t_sizes();
		apb(1'b1, 12'h414, 32'h03a1, 4'h3);
		pkt(8'h2a, 32'h03a1, 2);
		apb(1'b1, 12'h47c, 32'h00550000, 4'h4);
		pkt(8'hf9, 32'h55, 1);
		apb(1'b1, 12'h404, 32'h12340000, 4'hc);
		pkt(8'h0a, 32'h1234, 2);
		apb(1'b1, 12'h400, 32'h0, 4'h5);
		chk(er, 1'b1);
		apb(1'b1, 12'h400, 32'h44332211, 4'hf);
		pkt(8'h03, 32'h44332211, 4);
		$display("TB: sizes done");
	endtask

	task automatic t_page();
		apb(1'b1, 12'h494, 32'h77, 4'h1);
		pkt(8'h18, 32'h0, 0);
		pkt(8'h29, 32'h77, 1);
		apb(1'b0, OFS_PAGE, 32'h0, 4'h0);
		chk(rd, 32'h1);
		apb(1'b1, 12'h498, 32'h66, 4'h1);
		pkt(8'h31, 32'h66, 1);
		// A sync pulse while frozen must leave the page alone
		@(posedge clk_sys);
		ce        <= 1'b0;
		sync_done <= 1'b1;
		@(posedge clk_sys);
		ce        <= 1'b1;
		sync_done <= 1'b0;
		apb(1'b0, OFS_PAGE, 32'h0, 4'h0);
		chk(rd, 32'h1);
		@(posedge clk_sys);
		sync_done <= 1'b1;
		@(posedge clk_sys);
		sync_done <= 1'b0;
		apb(1'b0, OFS_PAGE, 32'h0, 4'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h494, 32'h77, 4'h1);
		pkt(8'h18, 32'h0, 0);
		pkt(8'h29, 32'h77, 1);
		apb(1'b1, 12'h788, 32'h5a, 4'h1);
		pkt(8'h78, 32'h0, 0);
		pkt(8'h11, 32'h5a, 1);
		apb(1'b1, 12'h404, 32'h3c, 4'h1);
		pkt(8'h08, 32'h0, 0);
		pkt(8'h09, 32'h3c, 1);
		$display("TB: paging done");
	endtask

	task automatic t_hw();
		mode <= 2'h1;
		hw(5'h3, 2'h3, 32'h44332211);
		pkt(8'h1f, 32'h44332211, 4);
		hw(5'h1, 2'h2, 32'h0123);
		pkt(8'h0e, 32'h0123, 2);
		hw(5'h2, 2'h0, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0, 4'h0);
		chk(rd[1], 1'b1);
		apb(1'b1, OFS_STATUS, 32'h2, 4'hf);
		apb(1'b0, OFS_STATUS, 32'h0, 4'h0);
		chk(rd[1], 1'b0);
		hw(5'h0, 2'h1, 32'h5);
		pkt(8'h05, 32'h5, 1);
		$display("TB: watch unit done");
	endtask

	task automatic t_fifo();
		mode <= 2'h2;
		for (int i = 0; i < 9; i++)
			apb(1'b1, 12'h408, 32'(i), 4'h1);
		// Parks in the watch slot while the FIFO is full
		hw(5'h4, 2'h1, 32'h7e);
		apb(1'b0, OFS_STATUS, 32'h0, 4'h0);
		chk(rd[15:8], 8'h8);
		chk(rd[0], 1'b1);
		chk(rd[2], 1'b1);
		apb(1'b0, 12'h408, 32'h0, 4'h0);
		chk(rd[0], 1'b0);
		mode <= 2'h1;
		for (int i = 0; i < 9; i++)
			pkt(8'h11, 32'(i), 1);
		pkt(8'h25, 32'h7e, 1);
		apb(1'b0, OFS_STATUS, 32'h0, 4'h0);
		chk(rd[15:8], 8'h0);
		chk(rd[0], 1'b0);
		$display("TB: buffer done");
	endtask

	task automatic print_verdict();
		$display("TB: %0d compared, %0d errors", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		{srst, ce} = 2'b11;
		{psel, penable, pwrite, hw_valid, sync_done} = 5'h0;
		{paddr, pwdata, pstrb, hw_id, hw_size, hw_data} = '0;
		mode = 2'h0;
		err_total = 0;
		n_compared = 0;
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		t_regs();
		t_sizes();
		t_page();
		t_hw();
		t_fifo();
		print_verdict();
	end

	// Tests need a few hundred cycles; this allows well over that
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end
endmodule // trace_source_packet_framer_tb
